/* logic/monitor_sleep_cfg.sv */
// Module: safety monitor and sleep configuration registers with their control logic
//
// Function
// R1 - In safety monitoring mode an alert packet is requested every 500 ms, 1 s or 1.5 s by the two-bit scan field.
// R2 - With monitoring not skipped, polling begins once the pin recovery delay has expired.
// R3 - With monitoring skipped, no polling is done and all GPIO outputs assert if the watchdog missed the delay.
// R4 - Four mask bits, reset high, block drive of safety-output pins during safety-measure states.
// R5 - In sleep the alert interval comes from bits 5:4 with the same 500 ms, 1 s, 1.5 s decode.
// R6 - With the sleep alert enable set, alert packets are requested in sleep at the sleep interval.
// R7 - With the sleep alert enable clear, its reset value, no alert packets are requested in sleep.
// R8 - Sleep is left when the balancing timer reaches the programmed notify time.
// R9 - Notify codes 000 to 011 mean 30, 60, 120 and 240 minutes; codes 1XX turn notification off.
// R10 - The scan interval register sits at index 0x70 with its upper six bits reserved and read as zero.
// R11 - The recovery delay is the setting times 10 ms plus 100 ms, and setting 0xFF disables it.
// R12 - An alert transaction timeout in sleep or monitoring sets the alert timeout flag and the link error flag.
// R13 - A reserved scan code 11 falls back to the 500 ms interval.
// R14 - The scan timer restarts on each mode entry and on each write of its interval field.
//
// The APB register port is this design's own decision.
module monitor_sleep_cfg
  import monitor_cfg_pkg::*;
#(
  parameter int unsigned SCAN_CYC   = SCAN_BASE_CYC,
  parameter int unsigned STEP_CYC   = REC_STEP_CYC,
  parameter int unsigned MINUTE_LEN = MINUTE_CYC
)(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        safety_monitor_mode,
  input  wire logic        sleep_mode,
  input  wire logic        watchdog_refresh,
  input  wire logic        safety_measure_state,
  input  wire logic [3:0]  safety_output_select,
  input  wire logic        alert_txn_timeout,
  input  wire logic        link_timeout,
  output logic             alert_packet_req,
  output logic             monitoring_active,
  output logic             assert_all_gpio,
  output logic [3:0]       safety_output_drive_en,
  output logic             sleep_exit,
  output logic             irq
);

  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_WAIT = 3'b010,
    REC_DONE = 3'b100
  } rec_state_t;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [1:0]        monitor_scan_interval_q, monitor_scan_interval_d;
  logic              skip_monitoring_q, skip_monitoring_d;
  logic [3:0]        safety_output_mask_q, safety_output_mask_d;
  logic [1:0]        sleep_scan_interval_q, sleep_scan_interval_d;
  logic              sleep_alert_packet_enable_q, sleep_alert_packet_enable_d;
  logic [2:0]        balancing_notify_time_q, balancing_notify_time_d;
  logic [7:0]        pin_recovery_delay_q, pin_recovery_delay_d;
  logic [ST_W-1:0]   status_q, status_d;
  logic [ST_W-1:0]   irq_mask_q, irq_mask_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  logic              scan_wr;
  logic              wr_en;
  logic              mapped;
  logic [31:0]       rd_word;
  logic [ST_W-1:0]   events;

  // Mode tracking and control state
  rec_state_t        rec_q, rec_d;
  logic [31:0]       step_cyc_q, step_cyc_d;
  logic [8:0]        step_cnt_q, step_cnt_d;
  logic              wd_seen_q, wd_seen_d;
  logic              mon_mode_q, slp_mode_q;
  logic [31:0]       min_cyc_q, min_cyc_d;
  logic [7:0]        minutes_q, minutes_d;
  logic              exit_done_q, exit_done_d;
  logic [7:0]        notify_min;
  logic              notify_hit;
  logic              all_gpio_q, all_gpio_d;
  logic              mon_act_q, mon_act_d;
  logic [3:0]        drive_q, drive_d;
  logic              exit_q, exit_d;
  logic              req_q, req_d;
  logic              irq_q, irq_d;

  scan_timer_if st ();

  // ---------------------------------------------------------------------------
  // APB decode: zero wait states, unmapped addresses answer with pslverr
  // ---------------------------------------------------------------------------
  always_comb
  begin
    mapped  = 1'b1;
    rd_word = '0;
    unique case (paddr)
      ADDR_SCAN:     rd_word = {30'd0, monitor_scan_interval_q};           // [R10]
      ADDR_OUTCTL:   rd_word = {24'd0, skip_monitoring_q, 3'd0, safety_output_mask_q};
      ADDR_SLEEP:    rd_word = {26'd0, sleep_scan_interval_q, sleep_alert_packet_enable_q,
                                balancing_notify_time_q};
      ADDR_RECOVERY: rd_word = {24'd0, pin_recovery_delay_q};
      ADDR_STATUS:   rd_word = {28'd0, status_q};
      ADDR_IRQ_MASK: rd_word = {28'd0, irq_mask_q};
      ADDR_STATE:    rd_word = {27'd0, rec_q, slp_mode_q, mon_mode_q};
      default:       mapped  = 1'b0;
    endcase
  end

  // Ready rises in the access cycle because the setup cycle prepares the answer
  assign wr_en     = psel && penable && pready_q && pwrite && !pslverr_q;
  assign scan_wr   = wr_en && (paddr == ADDR_SCAN);
  assign pready_d  = psel && !penable;
  assign prdata_d  = (psel && !penable && !pwrite) ? rd_word : prdata_q;
  assign pslverr_d = psel && !penable && !mapped;

  // Software writes, status set wins over write-one-clear
  always_comb
  begin
    monitor_scan_interval_d     = monitor_scan_interval_q;
    skip_monitoring_d           = skip_monitoring_q;
    safety_output_mask_d        = safety_output_mask_q;
    sleep_scan_interval_d       = sleep_scan_interval_q;
    sleep_alert_packet_enable_d = sleep_alert_packet_enable_q;
    balancing_notify_time_d     = balancing_notify_time_q;
    pin_recovery_delay_d        = pin_recovery_delay_q;
    irq_mask_d                  = irq_mask_q;
    status_d                    = status_q;
    if (wr_en)
    begin
      unique case (paddr)
        ADDR_SCAN:     monitor_scan_interval_d = pwdata[1:0];              // [R10]
        ADDR_OUTCTL:
        begin
          skip_monitoring_d    = pwdata[SKIP_BIT];
          safety_output_mask_d = pwdata[3:0];
        end
        ADDR_SLEEP:
        begin
          sleep_scan_interval_d       = pwdata[SLP_SCAN_LSB +: 2];
          sleep_alert_packet_enable_d = pwdata[SLP_EN_BIT];
          balancing_notify_time_d     = pwdata[2:0];
        end
        ADDR_RECOVERY: pin_recovery_delay_d = pwdata[7:0];
        ADDR_STATUS:   status_d = status_q & ~pwdata[ST_W-1:0];
        ADDR_IRQ_MASK: irq_mask_d = pwdata[ST_W-1:0];
        default:       status_d = status_q;
      endcase
    end
    status_d = status_d | events;
    irq_d    = |(status_d & irq_mask_d);
  end

  // Event sources for the sticky status bits
  always_comb
  begin
    events                = '0;
    events[ST_ALERT_TO]   = alert_txn_timeout && (safety_monitor_mode || sleep_mode); // [R12]
    events[ST_LINK_ERR]   = alert_txn_timeout || link_timeout;                        // [R12]
    events[ST_SLEEP_EXIT] = exit_d && !exit_q;
    events[ST_ALL_GPIO]   = all_gpio_d && !all_gpio_q;
  end

  // ---------------------------------------------------------------------------
  // Pin recovery delay and monitoring start
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rec_d      = rec_q;
    step_cyc_d = step_cyc_q;
    step_cnt_d = step_cnt_q;
    wd_seen_d  = wd_seen_q || watchdog_refresh;
    all_gpio_d = all_gpio_q;
    unique case (rec_q)
      REC_IDLE:
      begin
        wd_seen_d  = watchdog_refresh;                                    // [R3] Entry-cycle refresh counts
        step_cyc_d = '0;
        step_cnt_d = '0;
        all_gpio_d = 1'b0;
        if (safety_monitor_mode && !mon_mode_q)
          rec_d = REC_WAIT;
      end
      REC_WAIT:
      begin
        // A disabled delay never expires, so monitoring never starts
        if (pin_recovery_delay_q != RECOVERY_OFF)                         // [R11]
        begin
          if (step_cyc_q == 32'(STEP_CYC - 1))
          begin
            step_cyc_d = '0;
            step_cnt_d = step_cnt_q + 9'd1;
            if (step_cnt_q + 9'd1 >= {1'b0, pin_recovery_delay_q} + REC_OFFSET_STEP) // [R11]
            begin
              rec_d      = REC_DONE;
              all_gpio_d = skip_monitoring_q && !wd_seen_d;                // [R3]
            end
          end
          else
            step_cyc_d = step_cyc_q + 32'd1;
        end
      end
      REC_DONE:  rec_d = rec_q;
      default:   rec_d = REC_IDLE;
    endcase
    if (!safety_monitor_mode)
      rec_d = REC_IDLE;
  end

  // Monitoring only after the delay and only when not skipped
  assign mon_act_d = safety_monitor_mode && (rec_d == REC_DONE) && !skip_monitoring_q; // [R2] [R3]

  // Safety-output drive, masked during safety-measure states
  assign drive_d = safety_output_select & ~(safety_output_mask_q & {4{safety_measure_state}}); // [R4]

  // ---------------------------------------------------------------------------
  // Scan timer control: mode picks the field, reserved code acts as 500 ms
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [1:0] code;
    code       = sleep_mode ? sleep_scan_interval_q : monitor_scan_interval_q; // [R5] [R1]
    if (code == SCAN_RESERVED)
      code = SCAN_RST;                                                     // [R13]
    st.periods = code + 2'd1;                                              // [R1] [R5]
    st.run     = mon_act_q || (sleep_mode && sleep_alert_packet_enable_q); // [R6] [R7]
    st.restart = (safety_monitor_mode && !mon_mode_q) || (sleep_mode && !slp_mode_q) || scan_wr
                 || (wr_en && paddr == ADDR_SLEEP);                        // [R14]
  end

  assign req_d = st.tick && st.run;                                        // [R1] [R6]

  scan_timer #(
    .BASE_CYC (SCAN_CYC)
  ) u_scan_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .st      (st)
  );

  // ---------------------------------------------------------------------------
  // Balancing notify: minute count in sleep, exit once the time is reached
  // ---------------------------------------------------------------------------
  assign notify_min = NOTIFY_MIN_BASE << balancing_notify_time_q[1:0];     // [R9]
  assign notify_hit = !balancing_notify_time_q[2] && (minutes_q >= notify_min); // [R9] [R8]

  always_comb
  begin
    min_cyc_d   = min_cyc_q;
    minutes_d   = minutes_q;
    exit_done_d = exit_done_q;
    exit_d      = 1'b0;
    if (!sleep_mode || !slp_mode_q)
    begin
      min_cyc_d   = '0;
      minutes_d   = '0;
      exit_done_d = 1'b0;
    end
    else
    begin
      if (min_cyc_q == 32'(MINUTE_LEN - 1))
      begin
        min_cyc_d = '0;
        if (minutes_q != 8'hFF)
          minutes_d = minutes_q + 8'd1;
      end
      else
        min_cyc_d = min_cyc_q + 32'd1;
      if (notify_hit && !exit_done_q)
      begin
        exit_d      = 1'b1;                                                // [R8]
        exit_done_d = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register stage for all state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      monitor_scan_interval_q     <= SCAN_RST;                             // [R1]
      skip_monitoring_q           <= SKIP_RST;
      safety_output_mask_q        <= MASK_RST;                             // [R4]
      sleep_scan_interval_q       <= SCAN_RST;                             // [R5]
      sleep_alert_packet_enable_q <= 1'b0;                                 // [R7]
      balancing_notify_time_q     <= NOTIFY_RST;                           // [R9]
      pin_recovery_delay_q        <= RECOVERY_RST;
      status_q                    <= '0;
      irq_mask_q                  <= IRQ_MASK_RST;
      prdata_q                    <= '0;
      pready_q                    <= 1'b0;
      pslverr_q                   <= 1'b0;
      rec_q                       <= REC_IDLE;
      step_cyc_q                  <= '0;
      step_cnt_q                  <= '0;
      wd_seen_q                   <= 1'b0;
      mon_mode_q                  <= 1'b0;
      slp_mode_q                  <= 1'b0;
      min_cyc_q                   <= '0;
      minutes_q                   <= '0;
      exit_done_q                 <= 1'b0;
      all_gpio_q                  <= 1'b0;
      mon_act_q                   <= 1'b0;
      drive_q                     <= '0;
      exit_q                      <= 1'b0;
      req_q                       <= 1'b0;
      irq_q                       <= 1'b0;
    end
    else
    begin
      monitor_scan_interval_q     <= monitor_scan_interval_d;
      skip_monitoring_q           <= skip_monitoring_d;
      safety_output_mask_q        <= safety_output_mask_d;
      sleep_scan_interval_q       <= sleep_scan_interval_d;
      sleep_alert_packet_enable_q <= sleep_alert_packet_enable_d;
      balancing_notify_time_q     <= balancing_notify_time_d;
      pin_recovery_delay_q        <= pin_recovery_delay_d;
      status_q                    <= status_d;
      irq_mask_q                  <= irq_mask_d;
      prdata_q                    <= prdata_d;
      pready_q                    <= pready_d;
      pslverr_q                   <= pslverr_d;
      rec_q                       <= rec_d;
      step_cyc_q                  <= step_cyc_d;
      step_cnt_q                  <= step_cnt_d;
      wd_seen_q                   <= wd_seen_d;
      mon_mode_q                  <= safety_monitor_mode;
      slp_mode_q                  <= sleep_mode;
      min_cyc_q                   <= min_cyc_d;
      minutes_q                   <= minutes_d;
      exit_done_q                 <= exit_done_d;
      all_gpio_q                  <= all_gpio_d;
      mon_act_q                   <= mon_act_d;
      drive_q                     <= drive_d;
      exit_q                      <= exit_d;
      req_q                       <= req_d;
      irq_q                       <= irq_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign alert_packet_req       = req_q;
  assign monitoring_active      = mon_act_q;
  assign assert_all_gpio        = all_gpio_q;
  assign safety_output_drive_en = drive_q;
  assign sleep_exit             = exit_q;
  assign irq                    = irq_q;

endmodule // monitor_sleep_cfg

/* logic/monitor_cfg_pkg.sv */
// Package: register map, field layout, reset values and timing constants of the monitor config block
package monitor_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned SCAN_BASE_MS    = 500;              // Shortest scan interval
  localparam int unsigned SCAN_BASE_CYC   = SCAN_BASE_MS * CYC_PER_MS;
  localparam int unsigned REC_STEP_MS     = 10;               // Recovery delay step
  localparam int unsigned REC_STEP_CYC    = REC_STEP_MS * CYC_PER_MS;
  localparam int unsigned REC_OFFSET_MS   = 100;              // Recovery delay offset
  localparam logic [8:0]  REC_OFFSET_STEP = 9'(REC_OFFSET_MS / REC_STEP_MS);
  localparam int unsigned MINUTE_S        = 60;
  localparam int unsigned MINUTE_CYC      = MINUTE_S * CLK_HZ;

  // ---------------------------------------------------------------------------
  // Register indices (printed offsets) and byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_SCAN      = 8'h70;
  localparam logic [7:0]  IDX_OUTCTL    = 8'h72;
  localparam logic [7:0]  IDX_SLEEP     = 8'h74;
  localparam logic [7:0]  IDX_RECOVERY  = 8'h6C;
  localparam logic [7:0]  IDX_STATUS    = 8'h80;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'h81;
  localparam logic [7:0]  IDX_STATE     = 8'h82;
  localparam logic [11:0] ADDR_SCAN     = {2'b00, IDX_SCAN, 2'b00};
  localparam logic [11:0] ADDR_OUTCTL   = {2'b00, IDX_OUTCTL, 2'b00};
  localparam logic [11:0] ADDR_SLEEP    = {2'b00, IDX_SLEEP, 2'b00};
  localparam logic [11:0] ADDR_RECOVERY = {2'b00, IDX_RECOVERY, 2'b00};
  localparam logic [11:0] ADDR_STATUS   = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] ADDR_STATE    = {2'b00, IDX_STATE, 2'b00};

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          SKIP_BIT        = 7;
  localparam int          SLP_SCAN_LSB    = 4;
  localparam int          SLP_EN_BIT      = 3;
  localparam logic [1:0]  SCAN_RST        = 2'h0;
  localparam logic [1:0]  SCAN_RESERVED   = 2'h3;
  localparam logic        SKIP_RST        = 1'b0;
  localparam logic [3:0]  MASK_RST        = 4'hF;
  localparam logic [2:0]  NOTIFY_RST      = 3'h0;
  localparam logic [7:0]  RECOVERY_RST    = 8'h00;
  localparam logic [7:0]  RECOVERY_OFF    = 8'hFF;
  localparam logic [7:0]  NOTIFY_MIN_BASE = 8'h1E;           // 30 min, doubled per code step

  // Status bits (sticky, write one to clear)
  localparam int          ST_ALERT_TO     = 0;
  localparam int          ST_LINK_ERR     = 1;
  localparam int          ST_SLEEP_EXIT   = 2;
  localparam int          ST_ALL_GPIO     = 3;
  localparam int          ST_W            = 4;
  localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

endpackage : monitor_cfg_pkg

/* logic/scan_timer_if.sv */
// Interface: control and tick between the config block and its scan interval timer
interface scan_timer_if;
  logic       run;       // Count while high
  logic       restart;   // Restart from zero
  logic [1:0] periods;   // Interval length in base periods, 1 to 3
  logic       tick;      // One-cycle pulse at end of each interval

  modport ctrl  (output run, output restart, output periods, input tick);
  modport timer (input run, input restart, input periods, output tick);
endinterface : scan_timer_if

/* logic/scan_timer.sv */
// Module: alert packet scan interval timer
module scan_timer
  import monitor_cfg_pkg::*;
#(
  parameter int unsigned BASE_CYC = SCAN_BASE_CYC
)(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  scan_timer_if.timer st
);

  logic [31:0] cyc_q;
  logic [31:0] cyc_d;
  logic [1:0]  per_q;
  logic [1:0]  per_d;
  logic        tick_q;
  logic        tick_d;

  // ---------------------------------------------------------------------------
  // Next state: base period counter and period counter
  // ---------------------------------------------------------------------------
  always_comb
  begin
    cyc_d  = cyc_q;
    per_d  = per_q;
    tick_d = 1'b0;
    if (st.restart || !st.run)
    begin
      cyc_d = '0;
      per_d = '0;
    end
    else if (cyc_q == 32'(BASE_CYC - 1))
    begin
      cyc_d = '0;
      if (per_q + 2'd1 >= st.periods)
      begin
        per_d  = '0;
        tick_d = 1'b1;
      end
      else
        per_d = per_q + 2'd1;
    end
    else
      cyc_d = cyc_q + 32'd1;
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cyc_q  <= '0;
      per_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cyc_q  <= cyc_d;
      per_q  <= per_d;
      tick_q <= tick_d;
    end
  end

  assign st.tick = tick_q;

endmodule // scan_timer

/* tb/monitor_sleep_cfg_props.sv */
// Checker: port-level properties of the monitor and sleep config block
module monitor_sleep_cfg_props #(parameter int unsigned STEP_CYC = 4)(
  input wire logic       clk_sys, resetn, psel, penable, pready, pslverr,
  input wire logic       safety_monitor_mode, sleep_mode, safety_measure_state,
  input wire logic [3:0] safety_output_select, safety_output_drive_en,
  input wire logic       alert_packet_req, monitoring_active, assert_all_gpio, sleep_exit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Cycles in safety mode, saturated
  int unsigned since_q;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) since_q <= 0;
    else if (!safety_monitor_mode) since_q <= 0;
    else if (since_q < 9999) since_q <= since_q + 1;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no zero-wait answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_req; alert_packet_req |=> !alert_packet_req; endproperty
  a_req: assert property (p_req) else $error("request not a pulse");
  property p_req_mode; alert_packet_req |-> $past(safety_monitor_mode) || $past(sleep_mode); endproperty
  a_req_mode: assert property (p_req_mode) else $error("request outside modes");
  property p_drive; $past(resetn) && !$past(safety_measure_state)
    |-> safety_output_drive_en == $past(safety_output_select); endproperty
  a_drive: assert property (p_drive) else $error("drive masked outside measure");
  property p_drive_sub; (safety_output_drive_en & ~$past(safety_output_select)) == 4'h0; endproperty
  a_drive_sub: assert property (p_drive_sub) else $error("drive on unselected pin");
  property p_exit; sleep_exit |-> $past(sleep_mode) ##1 !sleep_exit; endproperty
  a_exit: assert property (p_exit) else $error("bad sleep exit pulse");
  property p_gpio; assert_all_gpio |-> !monitoring_active; endproperty
  a_gpio: assert property (p_gpio) else $error("polling with all outputs on");
  property p_delay; $rose(monitoring_active) |-> since_q >= 10 * STEP_CYC; endproperty
  a_delay: assert property (p_delay) else $error("polling before recovery delay");
  property p_off; $fell(safety_monitor_mode) |-> ##[1:3] !monitoring_active; endproperty
  a_off: assert property (p_off) else $error("polling after mode exit");
  c_req: cover property (alert_packet_req);
  c_exit: cover property (sleep_exit);
  c_gpio: cover property ($rose(assert_all_gpio));
endmodule // monitor_sleep_cfg_props

bind monitor_sleep_cfg monitor_sleep_cfg_props #(.STEP_CYC(STEP_CYC)) u_props (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .safety_monitor_mode(safety_monitor_mode),
  .sleep_mode(sleep_mode), .safety_measure_state(safety_measure_state), .sleep_exit(sleep_exit),
  .safety_output_select(safety_output_select), .safety_output_drive_en(safety_output_drive_en),
  .alert_packet_req(alert_packet_req), .monitoring_active(monitoring_active), .assert_all_gpio(assert_all_gpio));

/* tb/daisy_chain_model.sv */
// Partner: daisy chain that answers alert packets or lets them time out
module daisy_chain_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic alert_packet_req,
  input  wire logic silent,
  output logic      alert_txn_timeout
);
  timeunit 1ns;
  timeprecision 1ns;
  // A silent chain never answers, so the transaction times out three cycles on
  logic [2:0] pend_q;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) pend_q <= 3'h0;
    else pend_q <= {pend_q[1:0], alert_packet_req && silent};
  assign alert_txn_timeout = pend_q[2];
endmodule // daisy_chain_model

/* tb/test_safe_monitor_sleep_config.sv */
// Testbench: register, polling, sleep and safety output scenarios
module test_safe_monitor_sleep_config;
  timeunit 1ns;
  timeprecision 1ns;
  import monitor_cfg_pkg::*;
  localparam int SC = 20;
  logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        smm = 0, slp = 0, wdr = 0, meas = 0, silent = 0, ato, req, act, allg, sx, irq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  sel = 4'h0, den;
  int          failures = 0, check_count = 0, cyc = 0, last = 0, gap = 0, nreq = 0, nexit = 0;
  monitor_sleep_cfg #(.SCAN_CYC(SC), .STEP_CYC(4), .MINUTE_LEN(8)) u_monitor_sleep_cfg (.clk_sys, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .safety_monitor_mode(smm),
    .sleep_mode(slp), .watchdog_refresh(wdr), .safety_measure_state(meas), .safety_output_select(sel),
    .alert_txn_timeout(ato), .link_timeout(1'b0), .alert_packet_req(req), .monitoring_active(act),
    .assert_all_gpio(allg), .safety_output_drive_en(den), .sleep_exit(sx), .irq);
  daisy_chain_model u_daisy_chain_model (.clk_sys, .resetn, .alert_packet_req(req), .silent,
    .alert_txn_timeout(ato));
  initial forever #25 clk_sys = ~clk_sys;
  // Request spacing, exit count and a ceiling that cuts a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (req) {gap, last, nreq} <= {cyc - last, cyc, nreq + 1};
    if (sx) nexit <= nexit + 1;
    if (cyc > 5000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One APB transfer; result taken at the edge where pready is seen high
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task automatic wait_req(int n);
    int t = nreq + n;
    for (int i = 0; i < 400 && nreq < t; i++) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    apb(0, ADDR_SCAN, 32'h0);
    chk("scan reset", rd, 32'h0);
    apb(0, ADDR_OUTCTL, 32'h0);
    chk("outctl reset", rd, 32'hF);
    apb(0, ADDR_SLEEP, 32'h0);
    chk("sleep reset", rd, 32'h0);
    apb(1, ADDR_SCAN, 32'hFFFF_FFFF);
    apb(0, ADDR_SCAN, 32'h0);
    chk("scan reserved bits", rd, 32'h3);
    apb(0, 12'hFFC, 32'h0);
    chk("unmapped", err, 32'h1);
  endtask
  task automatic t_mon();
    apb(1, ADDR_SCAN, 32'h3);
    smm <= 1;
    idle(38);
    chk("early poll", act, 32'h0);
    idle(10);
    chk("poll on", act, 32'h1);
    wait_req(3);
    chk("reserved gap", gap, SC);
    apb(1, ADDR_SCAN, 32'h2);
    wait_req(2);
    chk("gap 1.5", gap, 3 * SC);
    silent <= 1;
    wait_req(1);
    silent <= 0;
    idle(8);
    apb(1, ADDR_IRQ_MASK, 32'h1);
    apb(0, ADDR_STATUS, 32'h0);
    chk("timeout flags", rd, 32'h3);
    chk("irq on", irq, 32'h1);
    smm <= 0;
    apb(1, ADDR_STATUS, 32'h3);
    idle(2);
    chk("irq off", irq, 32'h0);
  endtask
  task automatic t_skip();
    apb(1, ADDR_OUTCTL, 32'h85);
    {sel, meas} <= 5'h1F;
    idle(3);
    chk("masked drive", den, 32'hA);
    smm <= 1;
    idle(50);
    chk("all outputs", allg, 32'h1);
    smm <= 0;
    idle(3);
    smm <= 1;
    wdr <= 1;
    idle(1);
    wdr <= 0;
    idle(50);
    chk("refreshed", allg, 32'h0);
    {smm, meas} <= 2'b00;
  endtask
  task automatic t_sleep();
    apb(1, ADDR_SLEEP, 32'h1C);
    slp <= 1;
    wait_req(3);
    chk("sleep gap", gap, 2 * SC);
    apb(1, ADDR_SLEEP, 32'h14);
    rd = nreq;
    idle(100);
    chk("sleep quiet", nreq, rd);
    slp <= 0;
    apb(1, ADDR_SLEEP, 32'h0);
    slp <= 1;
    idle(230);
    chk("exit early", nexit, 32'h0);
    idle(40);
    chk("exit 30", nexit, 32'h1);
    slp <= 0;
    apb(1, ADDR_SLEEP, 32'h4);
    slp <= 1;
    idle(300);
    chk("notify off", nexit, 32'h1);
  endtask
  initial
  begin
    idle(6);
    resetn <= 1;
    idle(1);
    t_regs();
    t_mon();
    t_skip();
    t_sleep();
    conclude();
  end
endmodule // test_safe_monitor_sleep_config
